// file: src/flash_rd_pkg.sv
// Constants and types for the serial flash read front end: opcodes,
// address widths, dummy-cycle tables, lane masks, pin bundle and states.
// Assumes one system clock that oversamples the host's serial clock.
package flash_rd_pkg;

  localparam logic [7:0] READ_CMD = 8'h03;
  localparam logic [7:0] FAST_READ_CMD = 8'h0B;
  localparam logic [7:0] DUAL_OUTPUT_READ_CMD = 8'h3B;
  localparam logic [7:0] DUAL_IO_READ_CMD = 8'hBB;
  localparam logic [7:0] QUAD_OUTPUT_READ_CMD = 8'h6B;
  localparam logic [7:0] ENTER_WIDE_ADDR_CMD = 8'hB7;
  localparam logic [7:0] EXIT_WIDE_ADDR_CMD = 8'hE9;
  localparam logic [7:0] PARAM_TABLE_READ_CMD = 8'h5A;
  localparam logic [7:0] SIGNATURE_READ_CMD = 8'hAB;
  localparam logic [7:0] MAKER_DEVICE_CODE_READ_CMD = 8'h90;

  localparam logic [5:0] NARROW_ADDR_BITS = 6'h18;
  localparam logic [5:0] WIDE_ADDR_BITS = 6'h20;
  localparam logic [5:0] OPCODE_LAST_BIT = 6'h07;
  localparam logic WIDE_FLAG_RST = 1'b0;

  localparam logic [3:0] NO_DUMMY = 4'h0;
  localparam logic [3:0] DUMMY_STD [0:3] = '{4'h8, 4'h6, 4'h8, 4'hA};
  localparam logic [3:0] DUMMY_DIO [0:3] = '{4'h4, 4'h6, 4'h8, 4'hA};

  localparam logic [2:0] LANES_1 = 3'h1;
  localparam logic [2:0] LANES_2 = 3'h2;
  localparam logic [2:0] LANES_4 = 3'h4;
  localparam logic [3:0] OE_NONE = 4'h0;
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_DUAL = 4'h3;
  localparam logic [3:0] OE_QUAD = 4'hF;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] io;
  } pins_t;

  // Chip select idles high, everything else low.
  localparam logic [5:0] PINS_IDLE = 6'h20;

  typedef struct packed {
    logic addressed;
    logic rejectable;
    logic needs_quad;
    logic dual_io;
    logic [2:0] lanes;
    logic [3:0] dummy;
  } rd_mode_t;

  typedef enum logic [4:0] {
    ST_OPC = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_DUMMY = 5'b00100,
    ST_DATA = 5'b01000,
    ST_SKIP = 5'b10000
  } st_t;

  function automatic logic [3:0] dummy_cycles(input logic dual_io,
                                              input logic [1:0] sel);
    return dual_io ? DUMMY_DIO[sel] : DUMMY_STD[sel];
  endfunction : dummy_cycles

endpackage : flash_rd_pkg

// file: src/pin_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pins.
// Assumes each bit is an independent level; no bus coherence is kept.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 6,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        meta_r[i] <= RST_VAL[i];
        q_r[i] <= RST_VAL[i];
      end else begin
        meta_r[i] <= d_i[i];
        q_r[i] <= meta_r[i];
      end
    end
  end

  assign q_o = q_r;
endmodule : pin_sync

// file: src/flash_read_front.sv
// Serial flash command front end: wide-address mode and five read commands.
// Assumes CLK_I is at least eight times the serial clock, and a memory
// array on CLK_I that returns MEM_DATA_I one cycle after MEM_RD_O.
//
// Overview of operation
// - After reset, addressed commands take three address bytes.
// - Enter-wide opcode sets the wide-address flag; addresses become 32 bits.
// - Exit-wide opcode clears the wide-address flag; back to 24 bits.
// - Only exit opcode, reset or power-off leave wide-address mode.
// - Wide mode changes only the address length of commands.
// - Parameter, signature and maker-code reads keep their fixed format.
// - Reads default to 3-byte address; high area needs wide or extended bit.
// - Plain read samples on rising edges, drives on falling, no dummy.
// - Plain read streams data on line 1 until chip select rises.
// - Address starts anywhere, increments per byte, wraps to zero.
// - Fast read waits the selected dummy count, then single-line data.
// - Fast, dual and quad reads are refused while a write runs.
// - Dual-output read: single-line address, dummy, two bits per edge.
// - Dual-I/O read: two-bit address, dummy, two data bits per edge.
// - Quad-output read: single-line address, dummy, four bits per edge.
// - Dummy count comes from the two dummy-select configuration bits.
// - Select codes give 8,6,8,10 cycles; dual-I/O gets 4,6,8,10.
`timescale 1ns/1ps
module flash_read_front #(
  parameter int ADDR_W = 26
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CS_N_I,
  input wire logic SCLK_I,
  input wire logic [3:0] IO_I,
  output logic [3:0] IO_O,
  output logic [3:0] IO_OE_O,
  input wire logic WRITE_IN_PROGRESS_FLAG_I,
  input wire logic QUAD_ENABLE_BIT_I,
  input wire logic EXTENDED_ADDR_REG_BIT_I,
  input wire logic DUMMY_SELECT_LO_I,
  input wire logic DUMMY_SELECT_HI_I,
  output logic WIDE_ADDR_FLAG_O,
  output logic CMD_REJECT_O,
  output logic MEM_RD_O,
  output logic [ADDR_W-1:0] MEM_ADDR_O,
  input wire logic [7:0] MEM_DATA_I
);

  flash_rd_pkg::pins_t pin;
  logic [5:0] pin_v;
  logic sclk_d_r;
  logic rise;
  logic fall;
  logic sel;

  flash_rd_pkg::st_t st_r;
  logic [5:0] cnt_r;
  logic [7:0] op_sh_r;
  logic [7:0] op_nxt;
  logic op_done;
  flash_rd_pkg::rd_mode_t dec;
  flash_rd_pkg::rd_mode_t mode_r;
  logic wide_r;
  logic reject_r;
  logic [31:0] addr_sh_r;
  logic [31:0] addr_in;
  logic [31:0] addr_full;
  logic [5:0] lanes_in;
  logic [5:0] abits;
  logic addr_last;
  logic [ADDR_W-1:0] addr_r;
  logic rd_r;
  logic rd_d_r;
  logic [7:0] fetch_r;
  logic [7:0] dsh_r;
  logic [7:0] cur;
  logic [2:0] dcnt_r;
  logic ld_byte;
  logic [3:0] io_r;
  logic [3:0] oe_r;
  logic [3:0] oe_want;

  pin_sync #(
    .W(6),
    .RST_VAL(flash_rd_pkg::PINS_IDLE)
  ) u_sync (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .d_i({CS_N_I, SCLK_I, IO_I}),
    .q_o(pin_v)
  );

  assign pin = flash_rd_pkg::pins_t'(pin_v);

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= pin.sclk;
    end
  end

  assign rise = pin.sclk & ~sclk_d_r;
  assign fall = ~pin.sclk & sclk_d_r;
  assign sel = ~pin.cs_n;

  // Fixed-format commands fall through as unaddressed so that the wide
  // flag never stretches their address; another block serves them.
  function automatic flash_rd_pkg::rd_mode_t decode(input logic [7:0] op,
                                                    input logic [1:0] dc);
    flash_rd_pkg::rd_mode_t m;
    m = '0;
    m.lanes = flash_rd_pkg::LANES_1;
    m.dummy = flash_rd_pkg::NO_DUMMY;
    case (op)
      flash_rd_pkg::READ_CMD: begin
        m.addressed = 1'b1;
      end
      flash_rd_pkg::FAST_READ_CMD: begin
        m.addressed = 1'b1;
        m.rejectable = 1'b1;
        m.dummy = flash_rd_pkg::dummy_cycles(1'b0, dc);
      end
      flash_rd_pkg::DUAL_OUTPUT_READ_CMD: begin
        m.addressed = 1'b1;
        m.rejectable = 1'b1;
        m.lanes = flash_rd_pkg::LANES_2;
        m.dummy = flash_rd_pkg::dummy_cycles(1'b0, dc);
      end
      flash_rd_pkg::DUAL_IO_READ_CMD: begin
        m.addressed = 1'b1;
        m.rejectable = 1'b1;
        m.dual_io = 1'b1;
        m.lanes = flash_rd_pkg::LANES_2;
        m.dummy = flash_rd_pkg::dummy_cycles(1'b1, dc);
      end
      flash_rd_pkg::QUAD_OUTPUT_READ_CMD: begin
        m.addressed = 1'b1;
        m.rejectable = 1'b1;
        m.needs_quad = 1'b1;
        m.lanes = flash_rd_pkg::LANES_4;
        m.dummy = flash_rd_pkg::dummy_cycles(1'b0, dc);
      end
      flash_rd_pkg::PARAM_TABLE_READ_CMD,
      flash_rd_pkg::SIGNATURE_READ_CMD,
      flash_rd_pkg::MAKER_DEVICE_CODE_READ_CMD: begin
        m.addressed = 1'b0;
      end
      default: begin
        m.addressed = 1'b0;
      end
    endcase
    return m;
  endfunction : decode

  assign op_nxt = {op_sh_r[6:0], pin.io[0]};
  assign op_done = sel && st_r == flash_rd_pkg::ST_OPC && rise &&
                   cnt_r == flash_rd_pkg::OPCODE_LAST_BIT;
  assign dec = decode(op_nxt, {DUMMY_SELECT_HI_I, DUMMY_SELECT_LO_I});

  assign lanes_in = mode_r.dual_io ? 6'h02 : 6'h01;
  assign abits = wide_r ? flash_rd_pkg::WIDE_ADDR_BITS
                        : flash_rd_pkg::NARROW_ADDR_BITS;
  assign addr_last = st_r == flash_rd_pkg::ST_ADDR && rise &&
                     cnt_r + lanes_in == abits;
  assign addr_in = mode_r.dual_io ? {addr_sh_r[29:0], pin.io[1:0]}
                                  : {addr_sh_r[30:0], pin.io[0]};
  // The extended-address bit only lifts 3-byte addresses.
  assign addr_full = wide_r ? addr_in
                   : {7'h00, EXTENDED_ADDR_REG_BIT_I, addr_in[23:0]};

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_r <= flash_rd_pkg::ST_OPC;
      cnt_r <= 6'h00;
    end else if (!sel) begin
      st_r <= flash_rd_pkg::ST_OPC;
      cnt_r <= 6'h00;
    end else begin
      case (st_r)
        flash_rd_pkg::ST_OPC: begin
          if (op_done) begin
            cnt_r <= 6'h00;
            if (!dec.addressed || (dec.needs_quad && !QUAD_ENABLE_BIT_I)) begin
              st_r <= flash_rd_pkg::ST_SKIP;
            end else if (dec.rejectable && WRITE_IN_PROGRESS_FLAG_I) begin
              st_r <= flash_rd_pkg::ST_SKIP;
            end else begin
              st_r <= flash_rd_pkg::ST_ADDR;
            end
          end else if (rise) begin
            cnt_r <= cnt_r + 6'h01;
          end
        end
        flash_rd_pkg::ST_ADDR: begin
          if (addr_last) begin
            cnt_r <= 6'h00;
            st_r <= (mode_r.dummy == flash_rd_pkg::NO_DUMMY) ?
                    flash_rd_pkg::ST_DATA : flash_rd_pkg::ST_DUMMY;
          end else if (rise) begin
            cnt_r <= cnt_r + lanes_in;
          end
        end
        flash_rd_pkg::ST_DUMMY: begin
          if (rise) begin
            if (cnt_r + 6'h01 == {2'h0, mode_r.dummy}) begin
              cnt_r <= 6'h00;
              st_r <= flash_rd_pkg::ST_DATA;
            end else begin
              cnt_r <= cnt_r + 6'h01;
            end
          end
        end
        flash_rd_pkg::ST_DATA, flash_rd_pkg::ST_SKIP: begin
          cnt_r <= cnt_r;
        end
        default: begin
          st_r <= flash_rd_pkg::ST_SKIP;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      op_sh_r <= 8'h00;
      addr_sh_r <= 32'h0000_0000;
      mode_r <= '0;
    end else begin
      if (sel && st_r == flash_rd_pkg::ST_OPC && rise) begin
        op_sh_r <= op_nxt;
      end
      if (op_done) begin
        mode_r <= dec;
        addr_sh_r <= 32'h0000_0000;
      end else if (sel && st_r == flash_rd_pkg::ST_ADDR && rise) begin
        addr_sh_r <= addr_in;
      end
    end
  end

  // Nothing but the two dedicated opcodes touches the flag.
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wide_r <= flash_rd_pkg::WIDE_FLAG_RST;
    end else if (op_done && op_nxt == flash_rd_pkg::ENTER_WIDE_ADDR_CMD) begin
      wide_r <= 1'b1;
    end else if (op_done && op_nxt == flash_rd_pkg::EXIT_WIDE_ADDR_CMD) begin
      wide_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      reject_r <= 1'b0;
    end else begin
      reject_r <= op_done && dec.addressed && dec.rejectable &&
                  WRITE_IN_PROGRESS_FLAG_I;
    end
  end

  // The next byte is fetched as soon as the current one is loaded, which
  // leaves a whole byte time for the array to answer.
  assign ld_byte = sel && st_r == flash_rd_pkg::ST_DATA && fall &&
                   dcnt_r == 3'h0;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      addr_r <= '0;
      rd_r <= 1'b0;
      rd_d_r <= 1'b0;
      fetch_r <= 8'h00;
    end else begin
      rd_r <= 1'b0;
      rd_d_r <= rd_r;
      if (rd_d_r) begin
        fetch_r <= MEM_DATA_I;
      end
      if (sel && addr_last) begin
        addr_r <= addr_full[ADDR_W-1:0];
        rd_r <= 1'b1;
      end else if (ld_byte) begin
        addr_r <= addr_r + ADDR_W'(1);
        rd_r <= 1'b1;
      end
    end
  end

  assign cur = (dcnt_r == 3'h0) ? fetch_r : dsh_r;

  always_comb begin
    case (mode_r.lanes)
      flash_rd_pkg::LANES_2: oe_want = flash_rd_pkg::OE_DUAL;
      flash_rd_pkg::LANES_4: oe_want = flash_rd_pkg::OE_QUAD;
      default: oe_want = flash_rd_pkg::OE_SINGLE;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      io_r <= 4'h0;
      oe_r <= flash_rd_pkg::OE_NONE;
      dsh_r <= 8'h00;
      dcnt_r <= 3'h0;
    end else if (!sel || st_r != flash_rd_pkg::ST_DATA) begin
      io_r <= 4'h0;
      oe_r <= flash_rd_pkg::OE_NONE;
      dcnt_r <= 3'h0;
    end else if (fall) begin
      oe_r <= oe_want;
      case (mode_r.lanes)
        flash_rd_pkg::LANES_2: begin
          io_r <= {2'h0, cur[7:6]};
          dsh_r <= {cur[5:0], 2'h0};
          dcnt_r <= dcnt_r + 3'h2;
        end
        flash_rd_pkg::LANES_4: begin
          io_r <= cur[7:4];
          dsh_r <= {cur[3:0], 4'h0};
          dcnt_r <= dcnt_r + 3'h4;
        end
        default: begin
          io_r <= {2'h0, cur[7], 1'b0};
          dsh_r <= {cur[6:0], 1'b0};
          dcnt_r <= dcnt_r + 3'h1;
        end
      endcase
    end
  end

  assign IO_O = io_r;
  assign IO_OE_O = oe_r;
  assign WIDE_ADDR_FLAG_O = wide_r;
  assign CMD_REJECT_O = reject_r;
  assign MEM_RD_O = rd_r;
  assign MEM_ADDR_O = addr_r;

  a_reset_narrow: assert property (@(posedge CLK_I)
    $fell(RST_I) |-> !WIDE_ADDR_FLAG_O)
    else $error("wide flag set after reset");

  a_enter_wide: assert property (@(posedge CLK_I) disable iff (RST_I)
    (op_done && op_nxt == flash_rd_pkg::ENTER_WIDE_ADDR_CMD)
      |=> WIDE_ADDR_FLAG_O && abits == flash_rd_pkg::WIDE_ADDR_BITS)
    else $error("enter opcode did not widen address");

  a_exit_wide: assert property (@(posedge CLK_I) disable iff (RST_I)
    (op_done && op_nxt == flash_rd_pkg::EXIT_WIDE_ADDR_CMD)
      |=> !WIDE_ADDR_FLAG_O && abits == flash_rd_pkg::NARROW_ADDR_BITS)
    else $error("exit opcode did not narrow address");

  a_wide_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    !(op_done && (op_nxt == flash_rd_pkg::ENTER_WIDE_ADDR_CMD ||
                  op_nxt == flash_rd_pkg::EXIT_WIDE_ADDR_CMD))
      |=> $stable(WIDE_ADDR_FLAG_O))
    else $error("wide flag changed without its opcodes");

  a_plain_nodummy: assert property (@(posedge CLK_I) disable iff (RST_I)
    (addr_last && sel && mode_r.dummy == flash_rd_pkg::NO_DUMMY)
      |=> st_r == flash_rd_pkg::ST_DATA)
    else $error("plain read did not go straight to data");

  a_cs_release: assert property (@(posedge CLK_I) disable iff (RST_I)
    !sel |=> IO_OE_O == flash_rd_pkg::OE_NONE)
    else $error("lines driven with chip select high");

  a_addr_step: assert property (@(posedge CLK_I) disable iff (RST_I)
    ld_byte |=> MEM_RD_O ##0 MEM_ADDR_O == $past(addr_r) + ADDR_W'(1))
    else $error("address did not step by one per byte");

  a_dummy_count: assert property (@(posedge CLK_I) disable iff (RST_I)
    (st_r == flash_rd_pkg::ST_DATA && $past(st_r) == flash_rd_pkg::ST_DUMMY)
      |-> $past(cnt_r) + 6'h01 == {2'h0, mode_r.dummy})
    else $error("dummy phase length wrong");

  a_busy_reject: assert property (@(posedge CLK_I) disable iff (RST_I)
    (op_done && dec.rejectable && WRITE_IN_PROGRESS_FLAG_I)
      |=> CMD_REJECT_O && st_r == flash_rd_pkg::ST_SKIP ##1 !CMD_REJECT_O)
    else $error("read not refused during write");

  a_data_lanes: assert property (@(posedge CLK_I) disable iff (RST_I)
    (sel && st_r == flash_rd_pkg::ST_DATA && fall) |=> IO_OE_O == oe_want)
    else $error("wrong lanes driven in data phase");

endmodule : flash_read_front

// file: sim/spi_host.sv
// Host controller model that drives the flash pins in SPI mode 0.
// Assumes clk_i is the bench clock; one serial clock is 8 of its cycles.
`timescale 1ns/1ps
module spi_host (
  input wire logic clk_i,
  input wire logic [3:0] io_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o
);
  logic [7:0] got [$];
  logic [3:0] smp;

  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    io_o = 4'h0;
    io_oe_o = 4'h0;
  end

  // Lines are sampled just before the rise, half a period after the fall.
  task automatic cyc(input logic [3:0] d, input logic [3:0] oe);
    sclk_o = 1'b0;
    io_o = d;
    io_oe_o = oe;
    repeat (4) @(posedge clk_i);
    #1;
    smp = io_i;
    sclk_o = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
  endtask : cyc

  task automatic frame(input logic [7:0] cmd, input logic [31:0] a,
                       input int aw, input int nd, input int ln,
                       input int nb);
    int k;
    logic [7:0] b;
    got.delete();
    b = 8'h00;
    cs_n_o = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    for (k = 7; k >= 0; k--) begin
      cyc({3'h0, cmd[k]}, 4'h1);
    end
    for (k = aw - 1; k >= 0; k = k - ((cmd == 8'hBB) ? 2 : 1)) begin
      if (cmd == 8'hBB) begin
        cyc({2'h0, a[k -: 2]}, 4'h3);
      end else begin
        cyc({3'h0, a[k]}, 4'h1);
      end
    end
    repeat (nd) cyc(4'h0, 4'h0);
    for (k = 0; k < nb * 8 / ln; k++) begin
      cyc(4'h0, 4'h0);
      case (ln)
        1: b = {b[6:0], smp[1]};
        2: b = {b[5:0], smp[1:0]};
        default: b = {b[3:0], smp};
      endcase
      if ((k + 1) % (8 / ln) == 0) begin
        got.push_back(b);
      end
    end
    sclk_o = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    cs_n_o = 1'b1;
    io_oe_o = 4'h0;
    repeat (8) @(posedge clk_i);
    #1;
  endtask : frame
endmodule : spi_host

// file: sim/serial_flash_read_addr_mode_tb.sv
// Self-checking bench for the serial flash read front end.
// Assumes spi_host as the far side and a small array model in the bench.
`timescale 1ns/1ps
module serial_flash_read_addr_mode_tb;
  logic clk, rst, busy, quad_en, xbit, dlo, dhi, cs_n, sclk, wide, rej, mrd;
  logic wide_m;
  logic [3:0] io_o, io_oe, h_io, h_oe, fill, io_w;
  logic [25:0] maddr;
  logic [7:0] mdata;
  int failures, checks, cycles, rejn, oen;
  int ds [4] = '{8, 6, 8, 10};
  int dd [4] = '{4, 6, 8, 10};
  logic [7:0] cmds [4] = '{8'h0B, 8'h3B, 8'hBB, 8'h6B};

  // Undriven lines toggle so a stale value can never look right.
  assign io_w = (io_oe & io_o) | (~io_oe & h_oe & h_io)
              | (~io_oe & ~h_oe & fill);

  flash_read_front #(.ADDR_W(26)) DUT (
    .CLK_I(clk), .RST_I(rst), .CS_N_I(cs_n), .SCLK_I(sclk), .IO_I(io_w),
    .IO_O(io_o), .IO_OE_O(io_oe), .WRITE_IN_PROGRESS_FLAG_I(busy),
    .QUAD_ENABLE_BIT_I(quad_en), .EXTENDED_ADDR_REG_BIT_I(xbit),
    .DUMMY_SELECT_LO_I(dlo), .DUMMY_SELECT_HI_I(dhi),
    .WIDE_ADDR_FLAG_O(wide), .CMD_REJECT_O(rej), .MEM_RD_O(mrd),
    .MEM_ADDR_O(maddr), .MEM_DATA_I(mdata)
  );

  spi_host host (
    .clk_i(clk), .io_i(io_w), .cs_n_o(cs_n), .sclk_o(sclk),
    .io_o(h_io), .io_oe_o(h_oe)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [7:0] mem_f(input logic [25:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ {6'h00, a[25:24]};
  endfunction : mem_f

  task automatic stop_test();
    $display("Checks %0d, failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk_data(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_data

  task automatic chk_flag(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: flag %h expected %h", $time, g, e);
    end
  endtask : chk_flag

  always @(posedge clk) begin
    mdata <= (mrd === 1'b1) ? mem_f(maddr) : ~mdata;
    fill <= ~fill;
    cycles <= cycles + 1;
    if (rej === 1'b1) rejn <= rejn + 1;
    if (io_oe !== 4'h0) oen <= oen + 1;
    if (cycles == 60000) begin
      failures++;
      stop_test();
    end
  end

  task automatic reset_dut();
    rst = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    wide_m = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk_flag(wide, 1'b0);
  endtask : reset_dut

  task automatic mode(input logic [7:0] cmd);
    host.frame(cmd, 32'h0000_0000, 0, 0, 1, 0);
    if (cmd == 8'hB7) wide_m = 1'b1;
    if (cmd == 8'hE9) wide_m = 1'b0;
    chk_flag(wide, wide_m);
  endtask : mode

  task automatic rd(input logic [7:0] cmd, input int dc,
                    input logic [31:0] a, input int nb);
    int ln, nd, r0, o0;
    logic known, rj;
    logic [25:0] ea;
    ln = 1;
    nd = ds[dc];
    known = 1'b1;
    case (cmd)
      8'h03: nd = 0;
      8'h0B: known = 1'b1;
      8'h3B: ln = 2;
      8'hBB: begin
        ln = 2;
        nd = dd[dc];
      end
      8'h6B: ln = 4;
      default: known = 1'b0;
    endcase
    {dhi, dlo} = dc[1:0];
    r0 = $urandom;
    xbit = r0[0];
    ea = wide_m ? a[25:0] : {1'b0, xbit, a[23:0]};
    rj = busy && known && cmd != 8'h03;
    r0 = rejn;
    o0 = oen;
    host.frame(cmd, a, (wide_m && known) ? 32 : 24, nd, ln, nb);
    chk_data(rejn - r0, {31'h0, rj});
    if (rj || !known || (cmd == 8'h6B && !quad_en)) begin
      chk_data(oen - o0, 0);
    end else begin
      chk_data(host.got.size(), nb);
      for (int i = 0; i < nb; i++) begin
        chk_data(host.got[i], mem_f(ea + 26'(i)));
      end
    end
  endtask : rd

  initial begin
    rst = 1'b1;
    busy = 1'b0;
    quad_en = 1'b1;
    xbit = 1'b0;
    dlo = 1'b0;
    dhi = 1'b0;
    mdata = 8'h00;
    fill = 4'h5;
    wide_m = 1'b0;
    failures = 0;
    checks = 0;
    cycles = 0;
    rejn = 0;
    oen = 0;
    void'($urandom(32'h2b74_2ed2));
    reset_dut();
    rd(8'h03, 0, $urandom, 3);
    mode(8'hB7);
    rd(8'h03, 0, 32'h03FF_FFFF, 2);
    rd(8'h5A, 0, $urandom, 1);
    chk_flag(wide, 1'b1);
    for (int w = 0; w < 2; w++) begin
      for (int c = 0; c < 4; c++) begin
        for (int d = 0; d < 4; d++) rd(cmds[c], d, $urandom, 2);
      end
      mode(8'hE9);
    end
    busy = 1'b1;
    for (int c = 0; c < 4; c++) rd(cmds[c], 0, $urandom, 1);
    rd(8'h03, 0, $urandom, 1);
    busy = 1'b0;
    quad_en = 1'b0;
    rd(8'h6B, 0, $urandom, 1);
    quad_en = 1'b1;
    mode(8'hB7);
    reset_dut();
    stop_test();
  end
endmodule : serial_flash_read_addr_mode_tb
